// ===== hw/ddc_top.sv
// Operation
// - Data moves on both strobe edges for reads and writes; writes maskable per byte.
// - Registered-high termination enable terminates data and strobes unless modes disable it.
// - Reset pin is active low, asynchronous; held high in normal operation.
// - Activate: select and row strobe low, others high; idle bank, bank and row.
// - Precharge: row and write strobe low; bit ten picks one bank or all.
// - Write to open bank; bit ten auto-precharge; chop bit low gives four beats.
// - Read to open bank with the same auto-precharge and chop encoding.
// - Mode load: all strobes low while idle; bank picks register, address is data.
// - Chip select high ignores every other command input in any state; here clock enable still enters power-down and exits power-down or self refresh.
// - Clock enable transitions compare previous-cycle level with command-cycle level.
// - Clock enable falling with idle command from idle enters power-down.
// - Clock enable rising with idle command exits power-down or self refresh.
// - Byte mask high blocks that write lane; lower and upper act independently.
// - One core access of eight words over four clocks, two words per clock.
// - Bursts start at the given column, eight beats or four when chopped.
// - At activate three bank lines pick the bank, address bits zero-eleven the row.
// - Read/write address is column; bit ten auto-precharge; bit twelve chop if enabled.
`timescale 1ns/1ps
`include "ddc_map.svh"
module ddc_top #(
  parameter int ROW_IDX_W = 2,
  parameter int COL_IDX_W = 3
) (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic                  link_clk,
  input  wire logic                  reset_n,
  input  wire logic                  cke,
  input  wire logic                  cs_n,
  input  wire logic                  ras_n,
  input  wire logic                  cas_n,
  input  wire logic                  we_n,
  input  wire logic [2:0]            bank_select,
  input  wire logic [12:0]           addr,
  input  wire logic                  termination_enable,
  input  wire logic                  lower_byte_mask,
  input  wire logic                  upper_byte_mask,
  input  wire logic [15:0]           data_lines_in,
  output logic      [15:0]           data_lines_out,
  output logic                       data_lines_oe_n,
  output logic                       strobe_out,
  output logic                       strobe_n_out,
  output logic                       strobe_oe_n,
  output logic                       termination_on,
  output logic                       cmd_event,
  output ddc_pkg::ddc_status_t       status
);
  localparam int AW = 3 + ROW_IDX_W + COL_IDX_W;
  localparam ddc_pkg::ddc_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 3'h0, 13'h0000};

  logic                 link_rst;
  ddc_pkg::ddc_pins_t   pins_in;
  ddc_pkg::ddc_pins_t   pins_s1;
  ddc_pkg::ddc_pins_t   pins_s2;
  logic                 odt_s1;
  logic                 odt_s2;
  logic                 cke_prev;
  logic                 cke_seen;
  logic [2:0]           code;
  logic                 quiet;
  logic                 idle_all;
  logic                 next_chop;
  ddc_pkg::ddc_cmd_t    next_cmd;
  ddc_pkg::ddc_pwr_t    pwr;
  logic [7:0]           open;
  logic [11:0]          row [8];
  logic [15:0]          mode [4];
  logic                 busy;
  logic                 wait_step;
  logic                 is_read;
  logic                 commit;
  logic [1:0]           cnt;
  logic [1:0]           last;
  logic                 b_ap;
  logic [2:0]           b_bank;
  logic [2:0]           b_col;
  logic                 consume;
  logic [AW-1:0]        mem_addr;
  logic [127:0]         acc;
  logic [15:0]          acc_be;
  logic [127:0]         rd_data;
  logic [15:0]          d_rise;
  logic [15:0]          d_fall;
  logic [1:0]           m_rise;
  logic [1:0]           m_fall;
  logic [31:0]          out_pair;
  logic                 rd_drive;
  ddc_pkg::ddc_status_t snap;
  logic                 evt_tgl;
  logic                 tgl_s;
  logic                 tgl_d;

  // Lane of a beat within the core word, sequential from the start column
  function automatic logic [2:0] lane_of(input logic [2:0] col, input logic [1:0] c,
                                         input logic odd);
    lane_of = 3'(col + {c, odd});
  endfunction

  // Either reset source clears the link side
  assign link_rst = rst | ~reset_n;

  assign pins_in = '{cs_n, ras_n, cas_n, we_n, cke, bank_select, addr};

  // Command pins sampled twice; cke_prev is the level one cycle earlier
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      pins_s1  <= PINS_IDLE;
      pins_s2  <= PINS_IDLE;
      odt_s1   <= 1'b0;
      odt_s2   <= 1'b0;
      cke_prev <= 1'b0;
    end else begin
      pins_s1  <= pins_in;
      pins_s2  <= pins_s1;
      odt_s1   <= termination_enable;
      odt_s2   <= odt_s1;
      cke_prev <= pins_s2.cke;
    end
  end

  assign code     = {pins_s2.ras_n, pins_s2.cas_n, pins_s2.we_n};
  assign quiet    = pins_s2.cs_n || (code == `DDC_CODE_IDLE);
  assign idle_all = (open == 8'h00) && !busy;

  // Chop only honoured from the address when the mode allows on-the-fly
  always_comb begin
    if (mode[0][`DDC_MR_BURST_MSB:`DDC_MR_BURST_LSB] == `DDC_MR_BURST_OTF) begin
      next_chop = !pins_s2.addr[`DDC_CHOP_BIT];
    end else begin
      next_chop = mode[0][`DDC_MR_BURST_MSB:`DDC_MR_BURST_LSB] == `DDC_MR_BURST_FIX4;
    end
  end

  // Command classification; low-power states only listen for an exit
  always_comb begin
    next_cmd = ddc_pkg::CMD_REFUSED;
    if (pwr != ddc_pkg::PWR_ON) begin
      if (!cke_prev && pins_s2.cke && quiet) begin
        next_cmd = (pwr == ddc_pkg::PWR_SELF) ? ddc_pkg::CMD_SELF_EXIT
                                              : ddc_pkg::CMD_POWER_UP;
      end else if (!pins_s2.cke) begin
        next_cmd = ddc_pkg::CMD_DESELECT;
      end
    end else if (cke_prev && !pins_s2.cke) begin
      if (quiet && idle_all) begin
        next_cmd = ddc_pkg::CMD_POWER_DOWN;
      end else if (!pins_s2.cs_n && code == `DDC_CODE_REFRESH && idle_all) begin
        next_cmd = ddc_pkg::CMD_SELF_ENTER;
      end
    end else if (pins_s2.cs_n) begin
      next_cmd = ddc_pkg::CMD_DESELECT;
    end else begin
      unique case (code)
        `DDC_CODE_IDLE: next_cmd = ddc_pkg::CMD_NO_OPERATION;
        `DDC_CODE_ACTIVATE: begin
          if (!open[pins_s2.bank]) begin
            next_cmd = ddc_pkg::CMD_ACTIVATE;
          end
        end
        `DDC_CODE_PRECHG: begin
          next_cmd = pins_s2.addr[`DDC_AUTO_PRE_BIT] ? ddc_pkg::CMD_PRECHARGE_ALL
                                                    : ddc_pkg::CMD_PRECHARGE;
        end
        `DDC_CODE_WRITE: begin
          if (open[pins_s2.bank] && !busy) begin
            next_cmd = ddc_pkg::CMD_WRITE;
          end
        end
        `DDC_CODE_READ: begin
          if (open[pins_s2.bank] && !busy) begin
            next_cmd = ddc_pkg::CMD_READ;
          end
        end
        `DDC_CODE_LOAD: begin
          if (idle_all) begin
            next_cmd = ddc_pkg::CMD_MODE_LOAD;
          end
        end
        `DDC_CODE_REFRESH: begin
          if (idle_all) begin
            next_cmd = ddc_pkg::CMD_REFRESH;
          end
        end
        `DDC_CODE_CAL: begin
          if (idle_all) begin
            next_cmd = pins_s2.addr[`DDC_AUTO_PRE_BIT] ? ddc_pkg::CMD_CAL_LONG
                                                      : ddc_pkg::CMD_CAL_SHORT;
          end
        end
      endcase
    end
  end

  // Power state; reset behaves like power-down so the first cke rise wakes it
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      pwr <= ddc_pkg::PWR_DOWN;
    end else begin
      unique case (next_cmd)
        ddc_pkg::CMD_POWER_DOWN: pwr <= ddc_pkg::PWR_DOWN;
        ddc_pkg::CMD_SELF_ENTER: pwr <= ddc_pkg::PWR_SELF;
        ddc_pkg::CMD_POWER_UP,
        ddc_pkg::CMD_SELF_EXIT:  pwr <= ddc_pkg::PWR_ON;
        default:                 pwr <= pwr;
      endcase
    end
  end

  // Bank open map and row latch; auto-precharge closes at burst end
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      open <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        row[i] <= 12'h000;
      end
    end else begin
      if (b_ap && ((commit && !is_read) || (consume && is_read && cnt == last))) begin
        open[b_bank] <= 1'b0;
      end
      if (next_cmd == ddc_pkg::CMD_ACTIVATE) begin
        open[pins_s2.bank] <= 1'b1;
        row[pins_s2.bank]  <= pins_s2.addr[`DDC_ROW_MSB:0];
      end else if (next_cmd == ddc_pkg::CMD_PRECHARGE) begin
        open[pins_s2.bank] <= 1'b0;
      end else if (next_cmd == ddc_pkg::CMD_PRECHARGE_ALL) begin
        open <= 8'h00;
      end
    end
  end

  // Mode registers; the highest bank line is reserved and ignored
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      for (int i = 0; i < 4; i++) begin
        mode[i] <= `DDC_MR_RESET;
      end
    end else if (next_cmd == ddc_pkg::CMD_MODE_LOAD) begin
      mode[pins_s2.bank[1:0]] <= {3'h0, pins_s2.addr};
    end
  end

  // Termination waits for the first registered cke high after reset
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      cke_seen       <= 1'b0;
      termination_on <= 1'b0;
    end else begin
      cke_seen       <= cke_seen | pins_s2.cke;
      termination_on <= odt_s2 && cke_seen &&
                        (|(mode[1] & `DDC_RTT_NOM_MASK) ||
                         |(mode[2] & `DDC_RTT_WR_MASK));
    end
  end

  // Burst sequencer: one wait edge, then one beat pair per clock
  assign consume = busy && !wait_step && !commit;

  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      busy      <= 1'b0;
      wait_step <= 1'b0;
      is_read   <= 1'b0;
      commit    <= 1'b0;
      cnt       <= 2'h0;
      last      <= 2'h0;
      b_ap      <= 1'b0;
      b_bank    <= 3'h0;
      b_col     <= 3'h0;
      mem_addr  <= '0;
    end else if (next_cmd == ddc_pkg::CMD_WRITE || next_cmd == ddc_pkg::CMD_READ) begin
      busy      <= 1'b1;
      wait_step <= 1'b1;
      is_read   <= next_cmd == ddc_pkg::CMD_READ;
      cnt       <= 2'h0;
      last      <= next_chop ? `DDC_LAST_CHOP : `DDC_LAST_FULL;
      b_ap      <= pins_s2.addr[`DDC_AUTO_PRE_BIT];
      b_bank    <= pins_s2.bank;
      b_col     <= pins_s2.addr[2:0];
      mem_addr  <= {pins_s2.bank, row[pins_s2.bank][ROW_IDX_W-1:0],
                    pins_s2.addr[COL_IDX_W+2:3]};
    end else if (busy) begin
      wait_step <= 1'b0;
      if (commit) begin
        commit <= 1'b0;
        busy   <= 1'b0;
      end else if (consume) begin
        cnt <= 2'(cnt + 2'h1);
        if (cnt == last) begin
          commit <= !is_read;
          busy   <= !is_read;
        end
      end
    end
  end

  // Write beats captured on both clock edges
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      d_rise <= 16'h0000;
      m_rise <= 2'h3;
    end else begin
      d_rise <= data_lines_in;
      m_rise <= {upper_byte_mask, lower_byte_mask};
    end
  end

  always_ff @(negedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      d_fall <= 16'h0000;
      m_fall <= 2'h3;
    end else begin
      d_fall <= data_lines_in;
      m_fall <= {upper_byte_mask, lower_byte_mask};
    end
  end

  // Assemble the eight-word core access; unwritten lanes stay disabled
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      acc    <= 128'h0;
      acc_be <= 16'h0000;
    end else if (busy && wait_step) begin
      acc_be <= 16'h0000;
    end else if (consume && !is_read) begin
      acc[{lane_of(b_col, cnt, 1'b0), 4'h0} +: 16]    <= d_rise;
      acc[{lane_of(b_col, cnt, 1'b1), 4'h0} +: 16]    <= d_fall;
      acc_be[{lane_of(b_col, cnt, 1'b0), 1'b0} +: 2] <= ~m_rise;
      acc_be[{lane_of(b_col, cnt, 1'b1), 1'b0} +: 2] <= ~m_fall;
    end
  end

  // Core array, one 8n-bit word per access
  ddc_mem #(
    .DW (128),
    .AW (AW)
  ) u_mem (
    .clk     (link_clk),
    .wr_en   (commit),
    .wr_be   (acc_be),
    .wr_data (acc),
    .rd_en   (busy && wait_step && is_read),
    .addr    (mem_addr),
    .rd_data (rd_data)
  );

  // Read serialiser: high half of the clock carries the even beat
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      out_pair <= 32'h0000_0000;
      rd_drive <= 1'b0;
    end else begin
      rd_drive <= consume && is_read;
      if (consume && is_read) begin
        out_pair <= {rd_data[{lane_of(b_col, cnt, 1'b0), 4'h0} +: 16],
                     rd_data[{lane_of(b_col, cnt, 1'b1), 4'h0} +: 16]};
      end
    end
  end

  // Double-rate pins follow the link clock phase while driving
  assign data_lines_out  = link_clk ? out_pair[31:16] : out_pair[15:0];
  assign data_lines_oe_n = ~rd_drive;
  assign strobe_out      = rd_drive & link_clk;
  assign strobe_n_out    = rd_drive & ~link_clk;
  assign strobe_oe_n     = ~rd_drive;

  // Snapshot held steady between events so the core side can sample it
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      snap    <= '{ddc_pkg::CMD_DESELECT, 3'h0, 1'b0, 1'b0, 8'h00, ddc_pkg::PWR_DOWN, 1'b0};
      evt_tgl <= 1'b0;
    end else if (next_cmd != ddc_pkg::CMD_DESELECT) begin
      snap    <= '{next_cmd, pins_s2.bank, pins_s2.addr[`DDC_AUTO_PRE_BIT], next_chop,
                   open, pwr, termination_on};
      evt_tgl <= ~evt_tgl;
    end
  end

  ddc_sync #(
    .W (1)
  ) u_evt_sync (
    .clk (mclk),
    .rst (rst),
    .d   (evt_tgl),
    .q   (tgl_s)
  );

  // Toggle edge marks a fresh snapshot; it changed with the toggle, at least two core clocks earlier
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tgl_d     <= 1'b0;
      cmd_event <= 1'b0;
      status    <= '{ddc_pkg::CMD_DESELECT, 3'h0, 1'b0, 1'b0, 8'h00, ddc_pkg::PWR_DOWN, 1'b0};
    end else begin
      tgl_d     <= tgl_s;
      cmd_event <= tgl_s ^ tgl_d;
      if (tgl_s ^ tgl_d) begin
        status <= snap;
      end
    end
  end
endmodule

// ===== hw/ddc_map.svh
`ifndef DDC_MAP_SVH
`define DDC_MAP_SVH

// Command codes as {row strobe, column strobe, write strobe} with select low
`define DDC_CODE_LOAD     3'h0
`define DDC_CODE_REFRESH  3'h1
`define DDC_CODE_PRECHG   3'h2
`define DDC_CODE_ACTIVATE 3'h3
`define DDC_CODE_WRITE    3'h4
`define DDC_CODE_READ     3'h5
`define DDC_CODE_CAL      3'h6
`define DDC_CODE_IDLE     3'h7

// Address bit positions
`define DDC_AUTO_PRE_BIT  10
`define DDC_CHOP_BIT      12
`define DDC_ROW_MSB       11

// Mode register fields
`define DDC_MR_RESET      16'h0000
`define DDC_MR_BURST_LSB  0
`define DDC_MR_BURST_MSB  1
`define DDC_MR_BURST_OTF  2'h1
`define DDC_MR_BURST_FIX4 2'h2
`define DDC_RTT_NOM_MASK  16'h0244
`define DDC_RTT_WR_MASK   16'h0600

// Burst lengths as last clock index, two beats per clock
`define DDC_LAST_FULL     2'h3
`define DDC_LAST_CHOP     2'h1

`endif

// ===== hw/ddc_pkg.sv
package ddc_pkg;

  typedef enum logic [3:0] {
    CMD_DESELECT,
    CMD_NO_OPERATION,
    CMD_ACTIVATE,
    CMD_PRECHARGE,
    CMD_PRECHARGE_ALL,
    CMD_WRITE,
    CMD_READ,
    CMD_MODE_LOAD,
    CMD_REFRESH,
    CMD_SELF_ENTER,
    CMD_SELF_EXIT,
    CMD_POWER_DOWN,
    CMD_POWER_UP,
    CMD_CAL_LONG,
    CMD_CAL_SHORT,
    CMD_REFUSED
  } ddc_cmd_t;

  typedef enum logic [1:0] {PWR_ON, PWR_DOWN, PWR_SELF} ddc_pwr_t;

  typedef struct packed {
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic        cke;
    logic [2:0]  bank;
    logic [12:0] addr;
  } ddc_pins_t;

  typedef struct packed {
    ddc_cmd_t   cmd;
    logic [2:0] bank;
    logic       auto_pre;
    logic       chop;
    logic [7:0] open;
    ddc_pwr_t   pwr;
    logic       term_on;
  } ddc_status_t;

endpackage

// ===== hw/ddc_sync.sv
`timescale 1ns/1ps
module ddc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  // Two-flop synchroniser; first stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// ===== hw/ddc_mem.sv
`timescale 1ns/1ps
module ddc_mem #(
  parameter int DW = 128,
  parameter int AW = 8
) (
  input  wire logic            clk,
  input  wire logic            wr_en,
  input  wire logic [DW/8-1:0] wr_be,
  input  wire logic [DW-1:0]   wr_data,
  input  wire logic            rd_en,
  input  wire logic [AW-1:0]   addr,
  output logic      [DW-1:0]   rd_data
);
  logic [DW-1:0] store [2**AW];

  // Byte-lane write; masked lanes keep old contents
  always_ff @(posedge clk) begin
    if (wr_en) begin
      for (int i = 0; i < DW/8; i++) begin
        if (wr_be[i]) begin
          store[addr][i*8 +: 8] <= wr_data[i*8 +: 8];
        end
      end
    end
  end

  // Registered read port
  always_ff @(posedge clk) begin
    if (rd_en) begin
      rd_data <= store[addr];
    end
  end
endmodule

// ===== dv/ddc_checker.sv
`timescale 1ns/1ps
module ddc_checker (
  input wire logic                 mclk,
  input wire logic                 rst,
  input wire logic                 link_clk,
  input wire logic                 reset_n,
  input wire logic                 termination_enable,
  input wire logic                 data_lines_oe_n,
  input wire logic                 strobe_out,
  input wire logic                 strobe_n_out,
  input wire logic                 strobe_oe_n,
  input wire logic                 termination_on,
  input wire logic                 cmd_event,
  input wire ddc_pkg::ddc_status_t status
);
  // Link clock: strobes, enables; core side: events
  a_strobe_pair: assert property (@(posedge link_clk) disable iff (rst)
    !strobe_oe_n |-> strobe_out != strobe_n_out) else $error("strobe pair not complementary");
  a_oe_paired: assert property (@(posedge link_clk) disable iff (rst)
    strobe_oe_n == data_lines_oe_n) else $error("strobe and data enables differ");
  a_status_by_event: assert property (@(posedge mclk) disable iff (rst)
    $changed(status) |-> cmd_event || $past(cmd_event)) else $error("status moved silently");
  a_event_single: assert property (@(posedge mclk) disable iff (rst)
    cmd_event |=> !cmd_event) else $error("event wider than one cycle");
  a_quiet_when_down: assert property (@(posedge mclk) disable iff (rst)
    status.pwr == ddc_pkg::PWR_DOWN |-> data_lines_oe_n) else $error("drive in power-down");
  // Link side: termination, reset, burst span
  a_term_needs_pin: assert property (@(posedge link_clk) disable iff (rst)
    termination_on |-> $past(termination_enable, 3))
    else $error("termination without request");
  a_reset_quiet: assert property (@(posedge link_clk) disable iff (rst)
    !reset_n |-> data_lines_oe_n && !termination_on) else $error("active during reset");
  a_burst_span: assert property (@(posedge link_clk) disable iff (rst)
    $fell(data_lines_oe_n) |-> (!data_lines_oe_n)[*2] ##1
    (data_lines_oe_n or ((!data_lines_oe_n)[*2] ##1 data_lines_oe_n)))
    else $error("read burst of wrong length");
  // Main scenarios reached
  c_read: cover property (@(posedge mclk) cmd_event ##1 status.cmd == ddc_pkg::CMD_READ);
  c_write: cover property (@(posedge mclk) cmd_event ##1 status.cmd == ddc_pkg::CMD_WRITE);
  c_self: cover property (@(posedge mclk) cmd_event ##1 status.cmd == ddc_pkg::CMD_SELF_ENTER);
endmodule

bind ddc_top ddc_checker chk (.mclk(mclk), .rst(rst), .link_clk(link_clk),
  .reset_n(reset_n), .termination_enable(termination_enable),
  .data_lines_oe_n(data_lines_oe_n), .strobe_out(strobe_out),
  .strobe_n_out(strobe_n_out), .strobe_oe_n(strobe_oe_n),
  .termination_on(termination_on), .cmd_event(cmd_event), .status(status));

// ===== dv/ddc_ctrl_model.sv
`timescale 1ns/1ps
module ddc_ctrl_model (
  input  wire logic        link_clk,
  input  wire logic [15:0] data_lines_out,
  input  wire logic        data_lines_oe_n,
  output logic             cke,
  output logic             cs_n,
  output logic             ras_n,
  output logic             cas_n,
  output logic             we_n,
  output logic [2:0]       bank_select,
  output logic [12:0]      addr,
  output logic             lower_byte_mask,
  output logic             upper_byte_mask,
  output logic [15:0]      data_lines_in
);
  logic [15:0] rd_q[$];
  // Clock enable low until the first exit, lines deselected
  initial begin
    cke = 1'b0;
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
    {upper_byte_mask, lower_byte_mask} = 2'h0;
    bank_select = 3'h0;
    addr = 13'h0000;
    data_lines_in = 16'hA5A5;
  end
  // One command per call, then deselect with scrambled lines
  task automatic send(input logic ck, input logic sel_n, input logic [2:0] code,
                      input logic [2:0] ba, input logic [12:0] a, input int nb,
                      input logic [15:0] wd, input logic [1:0] msk);
    @(negedge link_clk);
    cke = ck;
    cs_n = sel_n;
    {ras_n, cas_n, we_n} = code;
    bank_select = ba;
    addr = a;
    @(negedge link_clk);
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = ~code;
    bank_select = ~ba;
    addr = ~a;
    // Beats change mid-phase so both edges see settled data
    if (nb > 0) begin
      repeat (2) @(posedge link_clk);
      for (int j = 0; j < nb; j++) begin
        #20;
        data_lines_in = wd + 16'(j);
        {upper_byte_mask, lower_byte_mask} = msk;
        if (j % 2 == 1) @(negedge link_clk);
        else @(posedge link_clk);
      end
      #20;
      data_lines_in = ~data_lines_in;
      {upper_byte_mask, lower_byte_mask} = ~msk;
    end
  endtask
  // High half carries even beats, low half odd beats
  always @(link_clk) begin
    #20;
    if (data_lines_oe_n === 1'b0) rd_q.push_back(data_lines_out);
  end
endmodule

// ===== dv/test_dram_command_decoder.sv
`timescale 1ns/1ps
`include "ddc_map.svh"
module test_dram_command_decoder;
  logic                 mclk;
  logic                 rst;
  logic                 link_clk;
  logic                 reset_n;
  logic                 termination_enable;
  logic                 cke, cs_n, ras_n, cas_n, we_n;
  logic                 lower_byte_mask, upper_byte_mask;
  logic [2:0]           bank_select;
  logic [12:0]          addr;
  logic [15:0]          data_lines_in, data_lines_out;
  logic                 data_lines_oe_n, termination_on, cmd_event;
  ddc_pkg::ddc_status_t status;
  int                   n_mismatch = 0;
  int                   cmp_count = 0;
  int                   cycles = 0;

  ddc_top dut (.mclk(mclk), .rst(rst), .link_clk(link_clk), .reset_n(reset_n),
    .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .bank_select(bank_select), .addr(addr), .termination_enable(termination_enable),
    .lower_byte_mask(lower_byte_mask), .upper_byte_mask(upper_byte_mask),
    .data_lines_in(data_lines_in), .data_lines_out(data_lines_out),
    .data_lines_oe_n(data_lines_oe_n), .strobe_out(), .strobe_n_out(), .strobe_oe_n(),
    .termination_on(termination_on), .cmd_event(cmd_event), .status(status));

  ddc_ctrl_model ctl (.link_clk(link_clk), .data_lines_out(data_lines_out),
    .data_lines_oe_n(data_lines_oe_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .bank_select(bank_select), .addr(addr),
    .lower_byte_mask(lower_byte_mask), .upper_byte_mask(upper_byte_mask),
    .data_lines_in(data_lines_in));

  // Core clock and an unrelated link clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #40 link_clk = ~link_clk;
  end

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Hang guard, well above the expected run of under two thousand cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Issue one command and watch for its event; deselect expects silence
  task automatic run(input logic ck, input logic [2:0] code, input logic [2:0] ba,
                     input logic [12:0] a, input ddc_pkg::ddc_cmd_t exp, input int nb = 0,
                     input logic [15:0] wd = 16'h0000, input logic [1:0] msk = 2'h0);
    logic hit;
    hit = 1'b0;
    fork
      ctl.send(ck, exp == ddc_pkg::CMD_DESELECT, code, ba, a, nb, wd, msk);
      for (int k = 0; k < 100 && !hit; k++) begin
        @(posedge mclk);
        if (cmd_event === 1'b1) hit = 1'b1;
      end
    join
    @(negedge mclk);
    chk(hit, exp != ddc_pkg::CMD_DESELECT);
    if (hit) chk(status.cmd, exp);
    repeat (8) @(posedge link_clk);
    $display("test %s done", exp.name());
  endtask

  // Lanes hold upper 8'h22 from the masked write, lower lane index
  task automatic rd_chk(input int first, input int nb);
    chk(32'(ctl.rd_q.size()), 32'(nb));
    for (int i = 0; i < nb && i < ctl.rd_q.size(); i++)
      chk(ctl.rd_q[i], 16'h2200 | 16'((first + i) % 8));
    ctl.rd_q.delete();
  endtask

  initial begin
    rst = 1'b1;
    reset_n = 1'b0;
    termination_enable = 1'b0;
    repeat (16) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    reset_n = 1'b1;
    run(1'b0, `DDC_CODE_ACTIVATE, 3'h0, 13'h0000, ddc_pkg::CMD_DESELECT);
    run(1'b1, `DDC_CODE_IDLE, 3'h0, 13'h0000, ddc_pkg::CMD_POWER_UP);
    run(1'b1, `DDC_CODE_LOAD, 3'h0, 13'h0001, ddc_pkg::CMD_MODE_LOAD);
    run(1'b1, `DDC_CODE_LOAD, 3'h1, 13'h0004, ddc_pkg::CMD_MODE_LOAD);
    run(1'b1, `DDC_CODE_CAL, 3'h0, 13'h0400, ddc_pkg::CMD_CAL_LONG);
    run(1'b1, `DDC_CODE_CAL, 3'h0, 13'h0000, ddc_pkg::CMD_CAL_SHORT);
    run(1'b1, `DDC_CODE_REFRESH, 3'h0, 13'h0000, ddc_pkg::CMD_REFRESH);
    run(1'b1, `DDC_CODE_IDLE, 3'h5, 13'h0000, ddc_pkg::CMD_NO_OPERATION);
    chk(status.open, 8'h00);
    // Termination follows the pin once enabled in the modes
    @(negedge link_clk);
    termination_enable = 1'b1;
    repeat (4) @(negedge link_clk);
    chk(termination_on, 1'b1);
    termination_enable = 1'b0;
    repeat (4) @(negedge link_clk);
    chk(termination_on, 1'b0);
    run(1'b1, `DDC_CODE_READ, 3'h2, 13'h1000, ddc_pkg::CMD_REFUSED);
    run(1'b1, `DDC_CODE_ACTIVATE, 3'h3, 13'h0ABC, ddc_pkg::CMD_ACTIVATE);
    chk(status.bank, 3'h3);
    run(1'b1, `DDC_CODE_ACTIVATE, 3'h3, 13'h0000, ddc_pkg::CMD_REFUSED);
    run(1'b1, `DDC_CODE_WRITE, 3'h3, 13'h1000, ddc_pkg::CMD_WRITE, 8, 16'h1100);
    run(1'b1, `DDC_CODE_WRITE, 3'h3, 13'h1000, ddc_pkg::CMD_WRITE, 8, 16'h22A0, 2'h1);
    ctl.rd_q.delete();
    run(1'b1, `DDC_CODE_READ, 3'h3, 13'h1000, ddc_pkg::CMD_READ);
    rd_chk(0, 8);
    run(1'b1, `DDC_CODE_READ, 3'h3, 13'h0402, ddc_pkg::CMD_READ);
    rd_chk(2, 4);
    run(1'b1, `DDC_CODE_ACTIVATE, 3'h3, 13'h0001, ddc_pkg::CMD_ACTIVATE);
    run(1'b1, `DDC_CODE_PRECHG, 3'h3, 13'h0000, ddc_pkg::CMD_PRECHARGE);
    run(1'b1, `DDC_CODE_ACTIVATE, 3'h3, 13'h0002, ddc_pkg::CMD_ACTIVATE);
    run(1'b1, `DDC_CODE_PRECHG, 3'h0, 13'h0400, ddc_pkg::CMD_PRECHARGE_ALL);
    chk(status.open, 8'h08);
    run(1'b1, `DDC_CODE_READ, 3'h3, 13'h1000, ddc_pkg::CMD_REFUSED);
    run(1'b0, `DDC_CODE_IDLE, 3'h0, 13'h0000, ddc_pkg::CMD_POWER_DOWN);
    run(1'b1, `DDC_CODE_IDLE, 3'h0, 13'h0000, ddc_pkg::CMD_POWER_UP);
    run(1'b0, `DDC_CODE_REFRESH, 3'h0, 13'h0000, ddc_pkg::CMD_SELF_ENTER);
    run(1'b1, `DDC_CODE_IDLE, 3'h0, 13'h0000, ddc_pkg::CMD_SELF_EXIT);
    // Reset pin alone must clear termination and drive mid-run
    @(negedge link_clk);
    termination_enable = 1'b1;
    reset_n = 1'b0;
    repeat (4) @(negedge link_clk);
    chk({termination_on, data_lines_oe_n}, 2'h1);
    final_report();
  end
endmodule
